// >>> bbsi_consts.vh
// Purpose: shared constants of the byte and bit instruction unit
// Assumes: included by every design file of the unit
// Notes: definitions only
`ifndef BBSI_CONSTS_VH
`define BBSI_CONSTS_VH

// ----------------------------------------
// operation select codes
// ----------------------------------------
`define BBSI_OP_CBS 3'h0
`define BBSI_OP_MBS 3'h1
`define BBSI_OP_LBT 3'h2
`define BBSI_OP_SBT 3'h3
`define BBSI_OP_SFB 3'h4
`define BBSI_OP_CLR 3'h5
`define BBSI_OP_SET 3'h6
`define BBSI_OP_TST 3'h7

// ----------------------------------------
// byte address map
// ----------------------------------------
`define BBSI_BP_LO 16'h0004
`define BBSI_BP_HI 16'h07ff
`define BBSI_ACC_WORDS 14'h0000
`define BBSI_BYTE_STEP 16'h0001

// ----------------------------------------
// program counter steps from word 1
// ----------------------------------------
`define BBSI_W2_OFS 15'h0001
`define BBSI_W3_OFS 15'h0002
`define BBSI_P_ONE 15'h0001
`define BBSI_P_TWO 15'h0002
`define BBSI_P_NOSKIP 15'h0003
`define BBSI_P_SKIP1 15'h0004
`define BBSI_P_SKIP2 15'h0005

// ----------------------------------------
// counts and reset values
// ----------------------------------------
`define BBSI_CNT_ONE 16'h0001
`define BBSI_ZERO16 16'h0000
`define BBSI_ZERO15 15'h0000
`define BBSI_ZERO8 8'h00

// ----------------------------------------
// byte staging buffer
// ----------------------------------------
`define BBSI_FIFO_W 8
`define BBSI_FIFO_D 8
`define BBSI_FIFO_AW 3

`endif

// >>> bbsi_baddr.v
// Purpose: byte address to word address and byte select
// Assumes: all 16 bits are address, none is an indirect flag
// Notes: combinational
`include "bbsi_consts.vh"

module bbsi_baddr (
  input wire [15:0] baddr,
  input wire seg_mode,
  input wire [15:0] q_base,
  output wire [14:0] word_addr,
  output wire lo_sel
);

  // ----------------------------------------
  // base page relocation
  // ----------------------------------------
  wire on_base;
  wire [15:0] eff;

  assign on_base = seg_mode & (baddr >= `BBSI_BP_LO) & (baddr <= `BBSI_BP_HI);
  assign eff = on_base ? baddr + {q_base[14:0], 1'b0} : baddr;

  // ----------------------------------------
  // split: even byte is high half
  // ----------------------------------------
  assign word_addr = eff[15:1];
  assign lo_sel = eff[0];

endmodule // bbsi_baddr

// >>> bbsi_fifo.v
// Purpose: byte staging buffer with valid and ready on both sides
// Assumes: depth is a power of two
// Notes: flush empties it in one cycle
`include "bbsi_consts.vh"

module bbsi_fifo #(
  parameter WIDTH = `BBSI_FIFO_W,
  parameter DEPTH = `BBSI_FIFO_D,
  parameter AW = `BBSI_FIFO_AW
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] LVL_ONE = 1;
  localparam [AW:0] LVL_ZERO = 0;
  localparam [AW-1:0] PTR_ONE = 1;
  localparam [AW-1:0] PTR_ZERO = 0;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] level;
  wire push;
  wire pop;

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  assign in_ready = (level != FULL);
  assign out_valid = (level != LVL_ZERO);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst | flush) begin
      wr_ptr <= PTR_ZERO;
      rd_ptr <= PTR_ZERO;
      level <= LVL_ZERO;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_ONE;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_ONE;
      end
      case ({push, pop})
        2'b10: level <= level + LVL_ONE;
        2'b01: level <= level - LVL_ONE;
        default: level <= level;
      endcase
    end
  end

endmodule // bbsi_fifo

// >>> bbsi_exec.v
// Purpose: execution of byte string, byte and bit mask instructions
// Assumes: one memory word access at a time, request held until ack
// Notes: words 0 and 1 are the accumulators and never reach memory
`include "bbsi_consts.vh"

// Notes on behaviour
// - byte address is twice word plus half
// - all sixteen byte address bits are address
// - segmented mode relocates base page byte references
// - bytes 0-3 are accumulators, never violate
// - compare takes count pointer, strings in accumulators
// - unsigned byte compare stops at first difference
// - exit step and first accumulator per outcome
// - second accumulator ends at start plus count
// - string ops save remaining count on interrupt
// - load byte zero extends, second accumulator increments
// - move copies upward, both pointers increment
// - byte pointers wrap into the accumulators
// - every moved byte write to memory is protect checked
// - store byte merges low byte, protect checked
// - scan keys in first, address in second
// - test match no skip, termination match skips
// - scan wraps to zero and self terminates
// - clear bits under mask ones
// - set bits under mask ones
// - test all ones no skip, else skip
// - protect check on memory, not words 0-1
module bbsi_exec (
  input wire ref_clk,
  input wire sys_rst,
  input wire start,
  input wire [2:0] op,
  input wire [14:0] p_in,
  input wire [15:0] a_in,
  input wire [15:0] b_in,
  input wire seg_mode,
  input wire [15:0] q_base,
  input wire irq_req,
  output reg mem_req,
  output reg mem_we,
  output reg [14:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  input wire mem_viol,
  output reg busy,
  output reg done,
  output reg viol,
  output reg [15:0] a_out,
  output reg [15:0] b_out,
  output reg [14:0] p_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [10:0] S_IDLE = 11'h001;
  localparam [10:0] S_W2 = 11'h002;
  localparam [10:0] S_W3 = 11'h004;
  localparam [10:0] S_CNT = 11'h008;
  localparam [10:0] S_RDA = 11'h010;
  localparam [10:0] S_RDB = 11'h020;
  localparam [10:0] S_WRR = 11'h040;
  localparam [10:0] S_WRW = 11'h080;
  localparam [10:0] S_TGT = 11'h100;
  localparam [10:0] S_TWR = 11'h200;
  localparam [10:0] S_END = 11'h400;

  reg [10:0] st;
  reg [2:0] op_r;
  reg [14:0] p;
  reg [15:0] ptr;
  reg [15:0] w3;
  reg [15:0] cnt;
  reg [15:0] rd_left;
  reg [15:0] mask;
  reg [15:0] tw;
  reg [7:0] b1;
  reg [15:0] end_val;
  reg [14:0] pret;

  // ----------------------------------------
  // byte address forming
  // ----------------------------------------
  wire [14:0] wa_a;
  wire lo_a;
  wire [14:0] wa_b;
  wire lo_b;

  bbsi_baddr u_baddr_a (
    .baddr(a_out),
    .seg_mode(seg_mode),
    .q_base(q_base),
    .word_addr(wa_a),
    .lo_sel(lo_a)
  );

  bbsi_baddr u_baddr_b (
    .baddr(b_out),
    .seg_mode(seg_mode),
    .q_base(q_base),
    .word_addr(wa_b),
    .lo_sel(lo_b)
  );

  // ----------------------------------------
  // byte staging buffer for moves
  // ----------------------------------------
  wire f_in_ready;
  wire f_out_valid;
  wire [7:0] f_data;
  wire f_push;
  wire f_pop;

  // ----------------------------------------
  // access descriptor of the current state
  // ----------------------------------------
  reg acc_act;
  reg acc_we;
  reg [14:0] acc_addr;
  reg [15:0] acc_wdata;

  wire is_mbs = (op_r == `BBSI_OP_MBS);
  wire is_str = (op_r == `BBSI_OP_CBS) | is_mbs;
  wire acc_local = (acc_addr[14:1] == `BBSI_ACC_WORDS);
  wire [15:0] local_data = acc_addr[0] ? b_out : a_out;
  wire mem_hit = mem_req & mem_ack;
  wire acc_ok = acc_act & (acc_local | (mem_hit & ~mem_viol));
  wire [15:0] acc_data = acc_local ? local_data : mem_rdata;
  wire rd_lo = (st == S_RDA) ? lo_a : lo_b;
  wire [7:0] rbyte = rd_lo ? acc_data[7:0] : acc_data[15:8];
  wire [7:0] wbyte = is_mbs ? f_data : a_out[7:0];
  wire [15:0] merged = lo_b ? {tw[15:8], wbyte} : {wbyte, tw[7:0]};
  wire [15:0] bits_new = (op_r == `BBSI_OP_CLR) ? (tw & ~mask) : (tw | mask);

  assign f_push = acc_ok & (st == S_RDA) & is_mbs;
  assign f_pop = acc_ok & (st == S_WRW) & is_mbs;

  bbsi_fifo #(
    .WIDTH(`BBSI_FIFO_W),
    .DEPTH(`BBSI_FIFO_D),
    .AW(`BBSI_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .flush(st == S_IDLE),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data(rbyte),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  always @* begin
    acc_act = 1'b1;
    acc_we = 1'b0;
    acc_addr = `BBSI_ZERO15;
    acc_wdata = `BBSI_ZERO16;
    case (st)
      S_W2: acc_addr = p + `BBSI_W2_OFS;
      S_W3: acc_addr = p + `BBSI_W3_OFS;
      S_CNT: acc_addr = ptr[14:0];
      S_RDA: begin
        acc_addr = wa_a;
        acc_act = ~is_mbs | f_in_ready;
      end
      S_RDB: acc_addr = wa_b;
      S_WRR: begin
        acc_addr = wa_b;
        acc_act = ~is_mbs | f_out_valid;
      end
      S_WRW: begin
        acc_addr = wa_b;
        acc_we = 1'b1;
        acc_wdata = merged;
      end
      S_TGT: acc_addr = w3[14:0];
      S_TWR: begin
        acc_addr = w3[14:0];
        acc_we = 1'b1;
        acc_wdata = bits_new;
      end
      S_END: begin
        acc_addr = p + `BBSI_W3_OFS;
        acc_we = 1'b1;
        acc_wdata = end_val;
      end
      default: acc_act = 1'b0;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= S_IDLE;
      op_r <= `BBSI_OP_CBS;
      p <= `BBSI_ZERO15;
      ptr <= `BBSI_ZERO16;
      w3 <= `BBSI_ZERO16;
      cnt <= `BBSI_ZERO16;
      rd_left <= `BBSI_ZERO16;
      mask <= `BBSI_ZERO16;
      tw <= `BBSI_ZERO16;
      b1 <= `BBSI_ZERO8;
      end_val <= `BBSI_ZERO16;
      pret <= `BBSI_ZERO15;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `BBSI_ZERO15;
      mem_wdata <= `BBSI_ZERO16;
      busy <= 1'b0;
      done <= 1'b0;
      viol <= 1'b0;
      a_out <= `BBSI_ZERO16;
      b_out <= `BBSI_ZERO16;
      p_out <= `BBSI_ZERO15;
    end else begin
      done <= 1'b0;
      viol <= 1'b0;
      // memory request, held until ack
      if (acc_act & ~acc_local & ~mem_req) begin
        mem_req <= 1'b1;
        mem_we <= acc_we;
        mem_addr <= acc_addr;
        mem_wdata <= acc_wdata;
      end else if (mem_hit) begin
        mem_req <= 1'b0;
      end
      case (st)
        S_IDLE: begin
          if (start) begin
            op_r <= op;
            p <= p_in;
            a_out <= a_in;
            b_out <= b_in;
            busy <= 1'b1;
            case (op)
              `BBSI_OP_LBT: st <= S_RDB;
              `BBSI_OP_SFB: st <= S_RDB;
              `BBSI_OP_SBT: st <= S_WRR;
              default: st <= S_W2;
            endcase
          end
        end
        S_W2: begin
          if (acc_ok) begin
            ptr <= acc_data;
            st <= S_W3;
          end
        end
        S_W3: begin
          if (acc_ok) begin
            w3 <= acc_data;
            if (is_str & (acc_data != `BBSI_ZERO16)) begin
              cnt <= acc_data;
              rd_left <= acc_data;
              st <= S_RDA;
            end else begin
              st <= S_CNT;
            end
          end
        end
        S_CNT: begin
          if (acc_ok) begin
            mask <= acc_data;
            cnt <= acc_data;
            rd_left <= acc_data;
            st <= is_str ? S_RDA : S_TGT;
          end
        end
        S_RDA: begin
          if (is_mbs & ~f_in_ready) begin
            st <= S_WRR;
          end else if (acc_ok) begin
            if (is_mbs) begin
              a_out <= a_out + `BBSI_BYTE_STEP;
              rd_left <= rd_left - `BBSI_CNT_ONE;
              if (rd_left == `BBSI_CNT_ONE) begin
                st <= S_WRR;
              end
            end else begin
              b1 <= rbyte;
              st <= S_RDB;
            end
          end
        end
        S_RDB: begin
          if (acc_ok) begin
            case (op_r)
              `BBSI_OP_CBS: begin
                if (b1 != rbyte) begin
                  b_out <= b_out + cnt;
                  pret <= p + ((b1 < rbyte) ? `BBSI_P_SKIP1 : `BBSI_P_SKIP2);
                  end_val <= `BBSI_ZERO16;
                  st <= S_END;
                end else begin
                  a_out <= a_out + `BBSI_BYTE_STEP;
                  b_out <= b_out + `BBSI_BYTE_STEP;
                  cnt <= cnt - `BBSI_CNT_ONE;
                  if (cnt == `BBSI_CNT_ONE) begin
                    pret <= p + `BBSI_P_NOSKIP;
                    end_val <= `BBSI_ZERO16;
                    st <= S_END;
                  end else if (irq_req) begin
                    pret <= p;
                    end_val <= cnt - `BBSI_CNT_ONE;
                    st <= S_END;
                  end else begin
                    st <= S_RDA;
                  end
                end
              end
              `BBSI_OP_LBT: begin
                a_out <= {`BBSI_ZERO8, rbyte};
                b_out <= b_out + `BBSI_BYTE_STEP;
                p_out <= p + `BBSI_P_ONE;
                done <= 1'b1;
                busy <= 1'b0;
                st <= S_IDLE;
              end
              `BBSI_OP_SFB: begin
                if (rbyte == a_out[7:0]) begin
                  p_out <= p + `BBSI_P_ONE;
                  done <= 1'b1;
                  busy <= 1'b0;
                  st <= S_IDLE;
                end else if (rbyte == a_out[15:8]) begin
                  b_out <= b_out + `BBSI_BYTE_STEP;
                  p_out <= p + `BBSI_P_TWO;
                  done <= 1'b1;
                  busy <= 1'b0;
                  st <= S_IDLE;
                end else begin
                  b_out <= b_out + `BBSI_BYTE_STEP;
                  if (irq_req) begin
                    p_out <= p;
                    done <= 1'b1;
                    busy <= 1'b0;
                    st <= S_IDLE;
                  end
                end
              end
              default: st <= S_IDLE;
            endcase
          end
        end
        S_WRR: begin
          if (is_mbs & ~f_out_valid) begin
            if (irq_req) begin
              pret <= p;
              end_val <= cnt;
              st <= S_END;
            end else begin
              st <= S_RDA;
            end
          end else if (acc_ok) begin
            tw <= acc_data;
            st <= S_WRW;
          end
        end
        S_WRW: begin
          if (acc_ok) begin
            b_out <= b_out + `BBSI_BYTE_STEP;
            if (is_mbs) begin
              cnt <= cnt - `BBSI_CNT_ONE;
              if (cnt == `BBSI_CNT_ONE) begin
                pret <= p + `BBSI_P_NOSKIP;
                end_val <= `BBSI_ZERO16;
                st <= S_END;
              end else begin
                st <= S_WRR;
              end
            end else begin
              p_out <= p + `BBSI_P_ONE;
              done <= 1'b1;
              busy <= 1'b0;
              st <= S_IDLE;
            end
          end
        end
        S_TGT: begin
          if (acc_ok) begin
            tw <= acc_data;
            if (op_r == `BBSI_OP_TST) begin
              if ((acc_data & mask) == mask) begin
                p_out <= p + `BBSI_P_NOSKIP;
              end else begin
                p_out <= p + `BBSI_P_SKIP1;
              end
              done <= 1'b1;
              busy <= 1'b0;
              st <= S_IDLE;
            end else begin
              st <= S_TWR;
            end
          end
        end
        S_TWR: begin
          if (acc_ok) begin
            p_out <= p + `BBSI_P_NOSKIP;
            done <= 1'b1;
            busy <= 1'b0;
            st <= S_IDLE;
          end
        end
        S_END: begin
          if (acc_ok) begin
            p_out <= pret;
            done <= 1'b1;
            busy <= 1'b0;
            st <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
      // accumulator bytes written in place, write wins over stepping
      if (acc_ok & acc_we & acc_local) begin
        if (acc_addr[0]) begin
          b_out <= acc_wdata;
        end else begin
          a_out <= acc_wdata;
        end
      end
      // protect violation aborts with no write done
      if (mem_hit & mem_viol & (st != S_IDLE)) begin
        viol <= 1'b1;
        p_out <= p;
        done <= 1'b1;
        busy <= 1'b0;
        st <= S_IDLE;
      end
    end
  end

endmodule // bbsi_exec

// >>> bbsi_checker.sv
// Purpose: port assertions for the byte and bit instruction unit
// Assumes: one clock, sync active high reset
// Notes: bound to bbsi_exec
`include "bbsi_consts.vh"

module bbsi_checker (
  input wire ref_clk,
  input wire sys_rst,
  input wire start,
  input wire [2:0] op,
  input wire [14:0] p_in,
  input wire mem_req,
  input wire mem_we,
  input wire [14:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire mem_ack,
  input wire mem_viol,
  input wire busy,
  input wire done,
  input wire viol,
  input wire [15:0] a_out,
  input wire [14:0] p_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // captured instruction
  // ----------------------------------------
  logic [14:0] p_start;
  logic [2:0] op_start;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      p_start <= 15'h0000;
      op_start <= 3'h0;
    end else if (start && !busy) begin
      p_start <= p_in;
      op_start <= op;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_no_acc_word; mem_req |-> mem_addr > 15'h0001; endproperty
  a_no_acc_word: assert property (p_no_acc_word) else $error("accumulator word on bus");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_gap; mem_req && mem_ack |=> !mem_req; endproperty
  a_gap: assert property (p_gap) else $error("no idle after ack");
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_viol_done; viol |-> done && !busy; endproperty
  a_viol_done: assert property (p_viol_done) else $error("viol without done");
  property p_abort; mem_req && mem_ack && mem_viol |-> ##[1:4] viol; endproperty
  a_abort: assert property (p_abort) else $error("violation not reported");
  property p_viol_pc; viol |-> p_out == p_start; endproperty
  a_viol_pc: assert property (p_viol_pc) else $error("abort pc wrong");
  property p_lbt;
    done && !viol && op_start == `BBSI_OP_LBT |->
      a_out[15:8] == 8'h00 && p_out == p_start + 15'h0001;
  endproperty
  a_lbt: assert property (p_lbt) else $error("load byte result wrong");
  property p_tst;
    done && !viol && op_start == `BBSI_OP_TST |->
      p_out == p_start + 15'h0003 || p_out == p_start + 15'h0004;
  endproperty
  a_tst: assert property (p_tst) else $error("test bits exit wrong");
  property p_busy; start && !busy |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("start not taken");
endmodule // bbsi_checker

bind bbsi_exec bbsi_checker bbsi_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .start(start), .op(op), .p_in(p_in), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_viol(mem_viol),
  .busy(busy), .done(done), .viol(viol), .a_out(a_out), .p_out(p_out));

// >>> bbsi_mem_model.sv
// Purpose: main memory with protect check, variable wait
// Assumes: one request at a time, held until ack
// Notes: read data is not held after ack
module bbsi_mem_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire mem_req,
  input wire mem_we,
  input wire [14:0] mem_addr,
  input wire [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic mem_viol,
  input wire [3:0] wait_cyc,
  input wire prot_en,
  input wire [14:0] prot_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:32767];
  logic [3:0] cnt;
  wire hit = prot_en && mem_addr == prot_addr;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      mem_viol <= 1'b0;
      mem_rdata <= 16'h0000;
      cnt <= 4'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_viol <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= 4'h0;
    end else if (mem_req && cnt < wait_cyc) begin
      cnt <= cnt + 4'h1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      mem_viol <= hit;
      mem_rdata <= mem[mem_addr];
      if (mem_we && !hit) mem[mem_addr] <= mem_wdata;
    end
  end
endmodule // bbsi_mem_model

// >>> bbsi_tb.sv
// Purpose: self-checking bench of the byte and bit instruction unit
// Assumes: memory model on the memory port
// Notes: each scenario is one task
`include "bbsi_consts.vh"
`define MEM bbsi_mem_model_inst.mem
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, sys_rst = 1, start = 0, seg_mode = 0, irq_req = 0, prot_en = 0;
  logic [2:0] op = 0;
  logic [14:0] p_in = 0, prot_addr = 0;
  logic [15:0] a_in = 0, b_in = 0, q_base = 0;
  logic [3:0] wait_cyc = 0;
  wire mem_req, mem_we, mem_ack, mem_viol, busy, done, viol;
  wire [14:0] mem_addr, p_out;
  wire [15:0] mem_wdata, mem_rdata, a_out, b_out;
  int fail_count = 0, checks_done = 0, cyc = 0;
  bbsi_exec bbsi_exec_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start), .op(op),
    .p_in(p_in), .a_in(a_in), .b_in(b_in), .seg_mode(seg_mode), .q_base(q_base),
    .irq_req(irq_req), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_viol(mem_viol),
    .busy(busy), .done(done), .viol(viol), .a_out(a_out), .b_out(b_out), .p_out(p_out));
  bbsi_mem_model bbsi_mem_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_viol(mem_viol), .wait_cyc(wait_cyc),
    .prot_en(prot_en), .prot_addr(prot_addr));
  // ----------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------
  initial forever #5 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // one instruction, returns in the done cycle
  // ----------------------------------------
  task automatic run(input [2:0] o, input [14:0] p, input [15:0] a, input [15:0] b);
    int n;
    @(negedge ref_clk);
    op = o;
    p_in = p;
    a_in = a;
    b_in = b;
    start = 1;
    @(negedge ref_clk);
    start = 0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge ref_clk);
    `CHK(done, 1'b1)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_load();
    `MEM[15'h0100] = 16'h1234;
    `MEM[15'h4100] = 16'h5678;
    run(`BBSI_OP_LBT, 15'h0040, 16'hab98, 16'h0001);
    `CHK(a_out, 16'h0098)
    `CHK(b_out, 16'h0002)
    `CHK(p_out, 15'h0041)
    run(`BBSI_OP_LBT, 15'h0040, 16'hffff, 16'h0200);
    `CHK(a_out, 16'h0012)
    run(`BBSI_OP_LBT, 15'h0040, 16'h0000, 16'h8201);
    `CHK(a_out, 16'h0078)
    `CHK(b_out, 16'h8202)
    seg_mode = 1;
    q_base = 16'h0080;
    run(`BBSI_OP_LBT, 15'h0040, 16'h0000, 16'h0101);
    `CHK(a_out, 16'h0034)
    seg_mode = 0; // off for string ops
  endtask
  task automatic t_store();
    `MEM[15'h0100] = 16'h1234;
    wait_cyc = 3;
    run(`BBSI_OP_SBT, 15'h0040, 16'hff55, 16'h0201);
    `CHK(`MEM[15'h0100], 16'h1255)
    `CHK(b_out, 16'h0202)
    prot_en = 1;
    prot_addr = 15'h0100;
    run(`BBSI_OP_SBT, 15'h0040, 16'h0077, 16'h0201);
    `CHK(viol, 1'b1)
    `CHK(`MEM[15'h0100], 16'h1255)
    run(`BBSI_OP_SBT, 15'h0040, 16'h00c3, 16'h0000);
    `CHK(viol, 1'b0)
    `CHK(a_out, 16'hc3c3)
    prot_en = 0;
    wait_cyc = 0;
  endtask
  task automatic t_cmp();
    logic [15:0] w [3] = '{16'h3344, 16'hb344, 16'h1344};
    `MEM[15'h0201] = 16'h0300;
    `MEM[15'h0300] = 16'h0004;
    `MEM[15'h0400] = 16'h1122;
    `MEM[15'h0401] = 16'h3344;
    `MEM[15'h0500] = 16'h1122;
    for (int k = 0; k < 3; k++) begin
      `MEM[15'h0202] = 16'h0000;
      `MEM[15'h0501] = w[k];
      run(`BBSI_OP_CBS, 15'h0200, 16'h0800, 16'h0a00);
      `CHK(p_out, 15'h0203 + 15'(k))
      `CHK(a_out, (k == 0) ? 16'h0804 : 16'h0802)
      `CHK(b_out, 16'h0a04)
      `CHK(`MEM[15'h0202], 16'h0000)
    end
    `MEM[15'h0501] = 16'h3344;
    irq_req = 1;
    run(`BBSI_OP_CBS, 15'h0200, 16'h0800, 16'h0a00);
    irq_req = 0;
    `CHK(p_out, 15'h0200)
    `CHK(16'(`MEM[15'h0202] + a_out - 16'h0800), 16'h0004)
    run(`BBSI_OP_CBS, 15'h0200, a_out, b_out);
    `CHK(p_out, 15'h0203)
    `CHK(a_out, 16'h0804)
    `CHK(`MEM[15'h0202], 16'h0000)
  endtask
  task automatic t_move();
    for (int j = 0; j < 6; j++) `MEM[15'h0600 + 15'(j)] = 16'hffff;
    for (int j = 0; j < 5; j++) `MEM[15'h0400 + 15'(j)] = {8'(2 * j), 8'(2 * j + 1)};
    `MEM[15'h0201] = 16'h0301;
    `MEM[15'h0301] = 16'h000a;
    `MEM[15'h0202] = 16'h0000;
    wait_cyc = 2;
    run(`BBSI_OP_MBS, 15'h0200, 16'h0800, 16'h0c01);
    `CHK(`MEM[15'h0600], 16'hff00)
    for (int j = 1; j < 5; j++)
      `CHK(`MEM[15'h0600 + 15'(j)], {8'(2 * j - 1), 8'(2 * j)})
    `CHK(`MEM[15'h0605], 16'h09ff)
    `CHK(a_out, 16'h080a)
    `CHK(b_out, 16'h0c0b)
    `CHK(p_out, 15'h0203)
    `MEM[15'h0202] = 16'h0003;
    run(`BBSI_OP_MBS, 15'h0200, 16'h0800, 16'h0c01);
    `CHK(b_out, 16'h0c04)
    `CHK(`MEM[15'h0202], 16'h0000)
    irq_req = 1;
    run(`BBSI_OP_MBS, 15'h0200, 16'h0800, 16'h0c01);
    irq_req = 0;
    `CHK(p_out, 15'h0200)
    `CHK(`MEM[15'h0202], 16'h0002)
    `CHK(a_out, 16'h0808)
    prot_en = 1;
    prot_addr = 15'h0603;
    `MEM[15'h0603] = 16'hffff;
    `MEM[15'h0202] = 16'h0000;
    run(`BBSI_OP_MBS, 15'h0200, 16'h0800, 16'h0c01);
    `CHK(viol, 1'b1)
    `CHK(`MEM[15'h0603], 16'hffff)
    prot_en = 0;
    wait_cyc = 0;
  endtask
  task automatic t_scan();
    `MEM[15'h0400] = 16'h0102;
    `MEM[15'h0401] = 16'h4103;
    `MEM[15'h7fff] = 16'h0000;
    run(`BBSI_OP_SFB, 15'h0200, 16'h2e41, 16'h0800);
    `CHK(b_out, 16'h0802)
    `CHK(p_out, 15'h0201)
    `MEM[15'h0401] = 16'h2e03;
    run(`BBSI_OP_SFB, 15'h0200, 16'h2e41, 16'h0800);
    `CHK(b_out, 16'h0803)
    `CHK(p_out, 15'h0202)
    run(`BBSI_OP_SFB, 15'h0200, 16'h2e41, 16'hfffe);
    `CHK(b_out, 16'h0001)
    `CHK(p_out, 15'h0202)
  endtask
  task automatic t_bits();
    `MEM[15'h0201] = 16'h0300;
    `MEM[15'h0300] = 16'h0f0f;
    `MEM[15'h0202] = 16'h0310;
    `MEM[15'h0310] = 16'hffff;
    run(`BBSI_OP_CLR, 15'h0200, 16'h0000, 16'h0000);
    `CHK(`MEM[15'h0310], 16'hf0f0)
    run(`BBSI_OP_SET, 15'h0200, 16'h0000, 16'h0000);
    `CHK(`MEM[15'h0310], 16'hffff)
    run(`BBSI_OP_TST, 15'h0200, 16'h0000, 16'h0000);
    `CHK(p_out, 15'h0203)
    `MEM[15'h0310] = 16'hff0e;
    run(`BBSI_OP_TST, 15'h0200, 16'h0000, 16'h0000);
    `CHK(p_out, 15'h0204)
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    t_load();
    t_store();
    t_cmp();
    t_move();
    t_scan();
    t_bits();
    tally_and_finish();
  end
endmodule // testbench
